//--- inc/spi_pkg.sv
package spi_pkg;
  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int NUM_CS     = 4;   // Chip selects
  localparam int SEL_W      = 2;   // Select index width
  localparam int DIV_W      = 8;   // Divisor field width
  localparam int BITS_W     = 4;   // Word length code width
  localparam int DATA_W     = 16;  // Widest word
  localparam int EDGE_W     = 6;   // Serial clock edge counter
  localparam int FIFO_DEPTH = 32;  // Words in the buffer
  localparam int SYNC_N     = 3;   // Synchronised pins
  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int TDR_SEL_LSB = 16;  // Per-word select in transmit word
  localparam int TDR_FINAL   = 24;  // Final transfer flag bit
  localparam int FW_FINAL    = 16;  // Final flag in buffer word
  localparam int FW_SEL_LSB  = 17;  // Select in buffer word
  localparam int FW_W        = 19;  // Buffer word width
  localparam int SYN_SCLK    = 0;   // Sync lane: serial clock in
  localparam int SYN_SEL     = 1;   // Sync lane: select in
  localparam int SYN_DIN     = 2;   // Sync lane: data in
  // ***********************************************************
  // Values and reset values
  // ***********************************************************
  localparam logic [DIV_W-1:0]  DIV_ONE  = 8'h01;  // Fastest divisor
  localparam logic [BITS_W-1:0] CODE_MAX = 4'h8;   // Sixteen bits
  localparam logic [4:0]        BITS_MIN = 5'h08;  // Code zero length
  localparam logic [NUM_CS-1:0] RST_CS_N = 4'hf;   // All deselected
  localparam logic [EDGE_W-1:0] EXTRA_EDGES = 6'h02;  // One extra pulse
  // ***********************************************************
  // Engine states
  // ***********************************************************
  typedef enum {ST_IDLE, ST_XFER, ST_GAP} eng_st_e;
endpackage

//--- rtl/spi_ctrl.sv
`timescale 1ns/100ps
// ***********************************************************
// Transmit buffer
// ***********************************************************
module spi_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,        // System clock
  input  wire logic             rstn,       // Async reset, active low
  input  wire logic             flush,      // Empty the buffer
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Word written
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Word taken
  output logic      [WIDTH-1:0] out_data    // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];       // Storage
  logic [AW-1:0]    wr_ff, nxt_wr;     // Write pointer
  logic [AW-1:0]    rd_ff, nxt_rd;     // Read pointer
  logic [AW:0]      cnt_ff, nxt_cnt;   // Fill level
  logic             push, pop;         // Accepted moves
  // Pointer and level next values
  always_comb begin
    push    = in_valid & in_ready;
    pop     = out_valid & out_ready;
    nxt_wr  = wr_ff + AW'(push);
    nxt_rd  = rd_ff + AW'(pop);
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      nxt_wr  = '0;
      nxt_rd  = '0;
      nxt_cnt = '0;
    end
  end
  // Registers, flags kept as flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ff     <= '0;
      rd_ff     <= '0;
      cnt_ff    <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ff     <= nxt_wr;
      rd_ff     <= nxt_rd;
      cnt_ff    <= nxt_cnt;
      in_ready  <= nxt_cnt != FULL;
      out_valid <= nxt_cnt != '0;
    end
  end
  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end
  assign out_data = mem[rd_ff];
endmodule

// ***********************************************************
// Serial controller
// ***********************************************************
module spi_ctrl #(
  parameter int FIFO_DEPTH = spi_pkg::FIFO_DEPTH
) (
  input  wire logic                                       clk,                // System clock
  input  wire logic                                       rstn,               // Async reset, active low
  input  wire logic                                       soft_reset_cmd,     // Soft reset pulse
  input  wire logic                                       enable_cmd,         // Enable pulse
  input  wire logic                                       disable_cmd,        // Disable pulse
  input  wire logic                                       master_select_bit,  // 1 master, 0 slave
  input  wire logic                                       fixed_select,       // Fixed peripheral mode
  input  wire logic [spi_pkg::SEL_W-1:0]                  fixed_cs,           // Fixed select index
  input  wire logic                                       hold_select_after_last, // Keep select
  input  wire logic [spi_pkg::NUM_CS*spi_pkg::DIV_W-1:0]  clock_divisor,      // Per-select divisor
  input  wire logic [spi_pkg::NUM_CS*spi_pkg::BITS_W-1:0] word_bits,          // Per-select length code
  input  wire logic [spi_pkg::NUM_CS-1:0]                 clock_pol,          // Per-select polarity
  input  wire logic [spi_pkg::NUM_CS-1:0]                 inverted_phase_bit, // Per-select phase
  input  wire logic [31:0]                                transmit_data_reg,  // Word from DMA channel
  input  wire logic                                       tx_valid,           // Word offered
  output logic                                            tx_accept,          // Buffer has room
  output logic                                            serial_clock_pin,   // Serial clock out
  input  wire logic                                       serial_clock_in,    // Serial clock in (slave)
  output logic      [spi_pkg::NUM_CS-1:0]                 select_n,           // Chip selects, low active
  input  wire logic                                       select_in_n,        // Slave select in
  output logic                                            data_out,           // Serial data out
  input  wire logic                                       data_in,            // Serial data in
  output logic                                            pins_oe_n,          // Clock/select drive, low active
  output logic                                            data_oe_n,          // Data drive, low active
  output logic                                            transmit_empty_flag, // Nothing left to send
  output logic                                            tx_ready,           // Word moved to shifter
  output logic      [spi_pkg::DATA_W-1:0]                 rx_data,            // Word received
  output logic                                            rx_valid,           // Received word pulse
  output logic                                            dma_halfword,       // DMA size: halfword
  output logic                                            active              // Controller enabled
);
  // ***********************************************************
  // Buffer and pin synchronisers
  // ***********************************************************
  logic                        fifo_valid, fifo_pop;  // Buffer read side
  logic [spi_pkg::FW_W-1:0]    fifo_dout;             // Oldest word
  logic [spi_pkg::SYNC_N-1:0]  meta_ff, sync_ff, dly_ff; // Sync chain and delay
  logic [spi_pkg::SYNC_N-1:0]  pin_raw;               // Raw pins, one per lane
  assign pin_raw = {data_in, select_in_n, serial_clock_in};
  spi_fifo #(.WIDTH(spi_pkg::FW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (soft_reset_cmd),
    .in_valid (tx_valid),
    .in_ready (tx_accept),
    .in_data  ({transmit_data_reg[spi_pkg::TDR_SEL_LSB +: spi_pkg::SEL_W],
                transmit_data_reg[spi_pkg::TDR_FINAL], transmit_data_reg[spi_pkg::DATA_W-1:0]}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data (fifo_dout)
  );
  // Two flops per pin, third flop for edge finding
  for (genvar i = 0; i < spi_pkg::SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_ff[i] <= 1'b1;
        sync_ff[i] <= 1'b1;
        dly_ff[i]  <= 1'b1;
      end else begin
        meta_ff[i] <= pin_raw[i];
        sync_ff[i] <= meta_ff[i];
        dly_ff[i]  <= sync_ff[i];
      end
    end
  end
  // ***********************************************************
  // Engine state
  // ***********************************************************
  spi_pkg::eng_st_e             st_ff, nxt_st;          // Engine state
  logic [spi_pkg::DATA_W-1:0]   sh_ff, nxt_sh;          // Transmit shifter
  logic [spi_pkg::DATA_W-1:0]   rxs_ff, nxt_rxs;        // Receive shifter
  logic [spi_pkg::EDGE_W-1:0]   e_ff, nxt_e;            // Edges done
  logic [spi_pkg::EDGE_W-1:0]   tot_ff, nxt_tot;        // Edges in this word
  logic [spi_pkg::DIV_W-1:0]    dcnt_ff, nxt_dcnt;      // Divider count
  logic [spi_pkg::DIV_W-1:0]    div_ff, nxt_div;        // Active divisor
  logic [spi_pkg::DIV_W-1:0]    ldiv_ff, nxt_ldiv;      // Previous word divisor
  logic [spi_pkg::SEL_W-1:0]    sel_ff, nxt_sel;        // Active select
  logic                         inverted_phase_bit_ff, nxt_inverted_phase_bit;    // Active phase
  logic                         fin_ff, nxt_fin;        // Final flag of word
  logic                         extra_ff, nxt_extra;    // Extra pulse armed
  logic                         gap_ff, nxt_gap;        // Idle with select held
  logic                         weak_ff, nxt_weak;      // Half-done soft reset
  logic                         en_ff, nxt_en;          // Enabled
  logic                         sclk_ff, nxt_sclk;      // Serial clock out
  logic                         mosi_ff, nxt_mosi;      // Data out
  logic [spi_pkg::NUM_CS-1:0]   csn_ff, nxt_csn;        // Selects out
  logic                         txe_ff, nxt_txe;        // Empty flag
  logic                         txr_ff, nxt_txr;        // Shifter loaded pulse
  logic [spi_pkg::DATA_W-1:0]   rxd_ff, nxt_rxd;        // Received word
  logic                         rxv_ff, nxt_rxv;        // Received pulse
  logic                         half_ff, nxt_half;      // DMA size
  logic                         doe_ff, nxt_doe;        // Data drive, low active
  logic [spi_pkg::SEL_W-1:0]    sel_new;                // Select of next word
  logic [spi_pkg::DIV_W-1:0]    div_new;                // Its divisor
  logic [spi_pkg::BITS_W-1:0]   code_new;               // Its length code
  logic                         tick, cap, dup, r14;    // Edge, capture, repeat, slow-fast
  logic                         sclk_edge;              // Slave clock edge seen
  // Configuration of the next word
  always_comb begin
    sel_new = fixed_select ? fixed_cs : fifo_dout[spi_pkg::FW_SEL_LSB +: spi_pkg::SEL_W];
    if (!master_select_bit) begin
      sel_new = '0;
    end
    div_new  = clock_divisor[{sel_new, 3'h0} +: spi_pkg::DIV_W];
    if (div_new == '0) begin
      div_new = spi_pkg::DIV_ONE;
    end
    code_new = word_bits[{sel_new, 2'h0} +: spi_pkg::BITS_W];
    if (code_new > spi_pkg::CODE_MAX) begin
      code_new = spi_pkg::CODE_MAX;
    end
  end
  // Next values of the engine
  always_comb begin
    nxt_st = st_ff;  nxt_sh = sh_ff;  nxt_rxs = rxs_ff;  nxt_e = e_ff;  nxt_tot = tot_ff;
    nxt_dcnt = dcnt_ff;  nxt_div = div_ff;  nxt_ldiv = ldiv_ff;  nxt_sel = sel_ff;
    nxt_inverted_phase_bit = inverted_phase_bit_ff;  nxt_fin = fin_ff;  nxt_extra = extra_ff;  nxt_gap = gap_ff;
    nxt_weak = weak_ff;  nxt_en = en_ff;  nxt_sclk = sclk_ff;  nxt_mosi = mosi_ff;
    nxt_csn = csn_ff;  nxt_rxd = rxd_ff;  nxt_txr = 1'b0;  nxt_rxv = 1'b0;
    fifo_pop = 1'b0;
    sclk_edge = sync_ff[spi_pkg::SYN_SCLK] ^ dly_ff[spi_pkg::SYN_SCLK];
    tick = master_select_bit ? (dcnt_ff == div_ff - spi_pkg::DIV_ONE) : sclk_edge;
    cap  = (e_ff[0] == ~inverted_phase_bit_ff);
    dup  = hold_select_after_last && div_new == spi_pkg::DIV_ONE && gap_ff && sel_new == sel_ff;
    r14  = ldiv_ff != spi_pkg::DIV_ONE && div_new == spi_pkg::DIV_ONE && clock_pol[sel_new]
           && !inverted_phase_bit[sel_new];
    if (enable_cmd) begin
      nxt_en = 1'b1;
    end else if (disable_cmd && master_select_bit) begin
      nxt_en = 1'b0;
    end
    case (st_ff)
      spi_pkg::ST_IDLE: begin
        if (master_select_bit) begin
          nxt_sclk = clock_pol[sel_new];
        end
        if (en_ff && (master_select_bit ? fifo_valid : !sync_ff[spi_pkg::SYN_SEL])) begin
          nxt_st    = spi_pkg::ST_XFER;
          nxt_e     = '0;
          nxt_dcnt  = '0;
          nxt_rxs   = '0;
          nxt_div   = div_new;
          nxt_sel   = sel_new;
          nxt_inverted_phase_bit = inverted_phase_bit[sel_new];
          nxt_fin   = fifo_valid & fifo_dout[spi_pkg::FW_FINAL];
          nxt_extra = master_select_bit && ((div_new == spi_pkg::DIV_ONE && code_new[0])
                      || r14);
          nxt_tot   = {({1'b0, code_new} + spi_pkg::BITS_MIN), 1'b0}
                      + (nxt_extra ? spi_pkg::EXTRA_EDGES : '0);
          nxt_sh    = fifo_valid ? fifo_dout[spi_pkg::DATA_W-1:0] << (spi_pkg::CODE_MAX - code_new) : '0;
          nxt_mosi  = nxt_sh[spi_pkg::DATA_W-1];
          fifo_pop  = fifo_valid && !(master_select_bit && dup);
          nxt_txr   = fifo_pop;
          nxt_gap   = 1'b0;
          if (master_select_bit && !weak_ff) begin
            nxt_csn = ~(spi_pkg::NUM_CS'(1) << sel_new);
          end
        end
      end
      spi_pkg::ST_XFER: begin
        nxt_dcnt = dcnt_ff + spi_pkg::DIV_ONE;
        if (tick) begin
          nxt_dcnt = '0;
          nxt_e    = e_ff + 1'b1;
          nxt_sclk = master_select_bit ? ~sclk_ff : sclk_ff;
          if (master_select_bit && weak_ff) begin
            nxt_csn = ~(spi_pkg::NUM_CS'(1) << sel_ff);
          end
          if (e_ff < tot_ff - (extra_ff ? spi_pkg::EXTRA_EDGES : '0)) begin
            if (cap) begin
              nxt_rxs = {rxs_ff[spi_pkg::DATA_W-2:0], sync_ff[spi_pkg::SYN_DIN]};
            end else if (e_ff != '0) begin
              nxt_sh   = sh_ff << 1;
              nxt_mosi = sh_ff[spi_pkg::DATA_W-2];
            end
          end
          if (nxt_e == tot_ff) begin
            nxt_rxd  = nxt_rxs;
            nxt_rxv  = 1'b1;
            nxt_ldiv = div_ff;
            nxt_st   = master_select_bit ? spi_pkg::ST_GAP : spi_pkg::ST_IDLE;
            if (fixed_select && hold_select_after_last && fin_ff && !fifo_valid) begin
              nxt_csn = spi_pkg::RST_CS_N;
            end
          end
        end
        if (!master_select_bit && sync_ff[spi_pkg::SYN_SEL]) begin
          nxt_st = spi_pkg::ST_IDLE;
        end
      end
      spi_pkg::ST_GAP: begin
        nxt_dcnt = dcnt_ff + spi_pkg::DIV_ONE;
        if (tick) begin
          nxt_st  = spi_pkg::ST_IDLE;
          nxt_gap = hold_select_after_last && !fin_ff && !fifo_valid;
          if (!hold_select_after_last || fin_ff) begin
            nxt_csn = spi_pkg::RST_CS_N;
          end
        end
      end
      default: nxt_st = spi_pkg::ST_IDLE;
    endcase
    if (soft_reset_cmd) begin
      nxt_st = spi_pkg::ST_IDLE;  nxt_en = 1'b0;  nxt_csn = spi_pkg::RST_CS_N;
      nxt_gap = 1'b0;  nxt_ldiv = spi_pkg::DIV_ONE;  nxt_extra = 1'b0;
      nxt_weak = ~weak_ff;
    end
    nxt_txe  = (nxt_st != spi_pkg::ST_XFER) && !(fifo_valid && !fifo_pop);
    nxt_half = (fixed_select ? word_bits[spi_pkg::BITS_W-1:0] : code_new) != '0;
    nxt_doe  = !(master_select_bit || (nxt_st == spi_pkg::ST_XFER));
  end
  // Registers, all on the system clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= spi_pkg::ST_IDLE;  sh_ff <= '0;  rxs_ff <= '0;  e_ff <= '0;  tot_ff <= '0;
      dcnt_ff <= '0;  div_ff <= spi_pkg::DIV_ONE;  ldiv_ff <= spi_pkg::DIV_ONE;  sel_ff <= '0;
      inverted_phase_bit_ff <= 1'b0;  fin_ff <= 1'b0;  extra_ff <= 1'b0;  gap_ff <= 1'b0;  weak_ff <= 1'b0;
      en_ff <= 1'b0;  sclk_ff <= 1'b0;  mosi_ff <= 1'b0;  csn_ff <= spi_pkg::RST_CS_N;
      txe_ff <= 1'b1;  txr_ff <= 1'b0;  rxd_ff <= '0;  rxv_ff <= 1'b0;  half_ff <= 1'b0;
      doe_ff <= 1'b1;  pins_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;  sh_ff <= nxt_sh;  rxs_ff <= nxt_rxs;  e_ff <= nxt_e;  tot_ff <= nxt_tot;
      dcnt_ff <= nxt_dcnt;  div_ff <= nxt_div;  ldiv_ff <= nxt_ldiv;  sel_ff <= nxt_sel;
      inverted_phase_bit_ff <= nxt_inverted_phase_bit;  fin_ff <= nxt_fin;  extra_ff <= nxt_extra;  gap_ff <= nxt_gap;
      weak_ff <= nxt_weak;  en_ff <= nxt_en;  sclk_ff <= nxt_sclk;  mosi_ff <= nxt_mosi;
      csn_ff <= nxt_csn;  txe_ff <= nxt_txe;  txr_ff <= nxt_txr;  rxd_ff <= nxt_rxd;
      rxv_ff <= nxt_rxv;  half_ff <= nxt_half;  doe_ff <= nxt_doe;  pins_oe_n <= !master_select_bit;
    end
  end
  assign serial_clock_pin    = sclk_ff;
  assign data_out            = mosi_ff;
  assign select_n            = csn_ff;
  assign data_oe_n           = doe_ff;
  assign transmit_empty_flag = txe_ff;
  assign tx_ready            = txr_ff;
  assign rx_data             = rxd_ff;
  assign rx_valid            = rxv_ff;
  assign dma_halfword        = half_ff;
  assign active              = en_ff;
  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [spi_pkg::EDGE_W-1:0] tog_ff;  // Clock flips this word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog_ff <= '0;
    end else begin
      tog_ff <= (st_ff == spi_pkg::ST_IDLE) ? '0 : tog_ff + spi_pkg::EDGE_W'(sclk_ff != nxt_sclk);
    end
  end
  sequence s_word_done;
    st_ff == spi_pkg::ST_XFER && master_select_bit ##1 st_ff == spi_pkg::ST_GAP;
  endsequence
  sequence s_load;
    st_ff == spi_pkg::ST_IDLE && nxt_st == spi_pkg::ST_XFER && master_select_bit && !soft_reset_cmd;
  endsequence
  property p_slave_no_disable;
    en_ff && !master_select_bit && disable_cmd && !soft_reset_cmd && !enable_cmd |=> active;
  endproperty
  a_slave_no_disable: assert property (p_slave_no_disable) else $error("slave disabled");
  property p_odd_extra;
    s_load and (div_new == spi_pkg::DIV_ONE && code_new[0])
      |=> extra_ff && tot_ff == 6'(2 * (8 + $past(code_new))) + 6'h2;
  endproperty
  a_odd_extra: assert property (p_odd_extra) else $error("no extra pulse on odd length");
  property p_even_clean;
    s_load and (div_new == spi_pkg::DIV_ONE && !code_new[0] && ldiv_ff == spi_pkg::DIV_ONE)
      |=> !extra_ff && tot_ff == 6'(2 * (8 + $past(code_new)));
  endproperty
  a_even_clean: assert property (p_even_clean) else $error("extra pulse on even length");
  property p_slow_fast;
    s_load and (r14 && !soft_reset_cmd) |=> extra_ff;
  endproperty
  a_slow_fast: assert property (p_slow_fast) else $error("no pulse after slow select");
  property p_flip_count;
    s_word_done |-> tog_ff == tot_ff;
  endproperty
  a_flip_count: assert property (p_flip_count) else $error("clock flips mismatch");
  property p_repeat;
    s_load and dup |=> !tx_ready ##1 st_ff == spi_pkg::ST_XFER;
  endproperty
  a_repeat: assert property (p_repeat) else $error("ready raised on repeated word");
  property p_final_release;
    $rose(transmit_empty_flag) && $past(st_ff == spi_pkg::ST_XFER && fin_ff && fixed_select
      && hold_select_after_last && master_select_bit && !soft_reset_cmd) |-> select_n == spi_pkg::RST_CS_N;
  endproperty
  a_final_release: assert property (p_final_release) else $error("select held after final");
  property p_dma_size;
    fixed_select ##1 $stable(word_bits) |-> dma_halfword == (word_bits[3:0] != 4'h0);
  endproperty
  a_dma_size: assert property (p_dma_size) else $error("size not from select zero");
  property p_idle_pol;
    st_ff == spi_pkg::ST_IDLE && nxt_st == spi_pkg::ST_IDLE && master_select_bit && !soft_reset_cmd
      |=> serial_clock_pin == $past(clock_pol[sel_new]);
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong");
endmodule

//--- verification/spi_slave_model.sv
`timescale 1ns/100ps
// ***********************************************************
// Serial slave on select zero
// ***********************************************************
module spi_slave_model (
  input  wire logic        sclk,   // Serial clock
  input  wire logic        sel_n,  // Select, low active
  input  wire logic        mosi,   // Data from controller
  input  wire logic [15:0] reply,  // Word to return
  output logic             miso,   // Data to controller
  output logic [15:0]      got     // Word received
);
  logic [15:0] sh;  // Outgoing shift
  // Load at select, shift on trailing edge
  always @(negedge sel_n) sh = reply;
  always @(negedge sclk) if (!sel_n) sh = {sh[14:0], ~sh[15]};
  always @(posedge sclk) if (!sel_n) got = {got[14:0], mosi};
  // Released line shows inverse of last bit
  assign miso = sel_n ? ~sh[15] : sh[15];
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  logic        clk = 0, rstn = 0, tv = 0, mst = 1, sck_in = 0, ssel_n = 1;  // Bench drives
  logic [2:0]  cmd = 0;                // Soft reset, enable, disable
  logic [1:0]  fcs = 0;                // Fixed select
  logic [31:0] div = 32'h04040404;     // Divisors
  logic [15:0] bits = 16'h8888;        // Length codes
  logic [31:0] tdr = 0;                // Word offered
  logic [15:0] reply = 0, got, rxd;    // Slave words
  logic [3:0]  sel_n;                  // Selects
  logic        sck, mosi, miso, acc, empty, rdy, rxv, half, act;
  logic        hold = 0, fin_bit = 0;                 // Held select, final flag
  logic [3:0]  pol = 4'h0, phase = 4'hf, sel_at_rx;  // Polarity, phase, selects at word end
  int          fail_count = 0, num_checks = 0, seed = 32'hfab361f9, tog = 0, nrdy = 0, cyc = 0;
  int          nrxv = 0, n0 = 0, n1 = 0;              // Received words, snapshots
  always #50 clk = ~clk;
  always @(sck) tog++;
  // Ready pulses and hang limit
  always @(posedge clk) begin
    nrdy += (rdy === 1'b1);
    nrxv += (rxv === 1'b1);
    if (rxv === 1'b1) sel_at_rx = sel_n;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up;
    end
  end
  spi_ctrl dut_u (.clk(clk), .rstn(rstn), .soft_reset_cmd(cmd[2]), .enable_cmd(cmd[1]), .disable_cmd(cmd[0]),
    .master_select_bit(mst), .fixed_select(1'b1), .fixed_cs(fcs), .hold_select_after_last(hold),
    .clock_divisor(div), .word_bits(bits), .clock_pol(pol), .inverted_phase_bit(phase), .transmit_data_reg(tdr),
    .tx_valid(tv), .tx_accept(acc), .serial_clock_pin(sck), .serial_clock_in(sck_in), .select_n(sel_n),
    .select_in_n(ssel_n), .data_out(mosi), .data_in(miso), .pins_oe_n(), .data_oe_n(), .transmit_empty_flag(empty),
    .tx_ready(rdy), .rx_data(rxd), .rx_valid(rxv), .dma_halfword(half), .active(act));
  spi_slave_model slv_u (.sclk(sck), .sel_n(sel_n[0]), .mosi(mosi), .reply(reply), .miso(miso), .got(got));
  task automatic pulse(input int k);
    @(negedge clk) cmd[k] = 1;
    @(negedge clk) cmd[k] = 0;
  endtask
  task automatic push(input logic [31:0] w);
    @(negedge clk) begin tdr = w; tv = 1; end
    do @(posedge clk); while (acc !== 1'b1);
    @(negedge clk) tv = 0;
  endtask
  // One word out, wait for the received word
  task automatic xfer(input logic [15:0] w, output logic [15:0] d);
    int i;
    d = 16'h0;
    tog = 0;
    push({7'h0, fin_bit, 8'h0, w});
    for (i = 0; i < 600; i++) begin
      @(posedge clk);
      if (rxv === 1'b1) begin d = rxd; break; end
    end
    repeat (12) @(negedge clk);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    int c;
    logic [15:0] w, d;
    repeat (12) @(negedge clk);
    rstn = 1;
    pulse(2); pulse(2); pulse(1);
    {w, reply} = $random(seed);
    xfer(w, d);
    `CHK(d, reply)
    `CHK(got, w)
    div = 32'h01010101;
    // Length codes zero to eight at divisor one
    for (c = 0; c <= 8; c++) begin
      bits = {4{c[3:0]}};
      xfer(w, d);
      `CHK(tog, 2 * (8 + c) + ((c % 2) ? 2 : 0))
    end
    `CHK(nrdy, 10)
    pulse(0);
    for (c = 0; c < 32; c++) push($random(seed));
    `CHK(acc, 1'b0)
    pulse(1);
    for (c = 0; c < 2000 && empty !== 1'b1; c++) @(negedge clk);
    `CHK({empty, acc}, 2'b11)
    fcs = 1; bits = 16'h0002;
    repeat (3) @(negedge clk);
    `CHK(half, 1'b1)
    bits = 16'h0000;
    repeat (3) @(negedge clk);
    `CHK(half, 1'b0)
    // Slow select then fast select with polarity one, phase zero
    pol = 4'hf; phase = 4'h0; div = 32'h00000104; fcs = 0;
    xfer(w, d);
    fcs = 1;
    xfer(w, d);
    `CHK(tog, 18)
    pol = 4'h0; phase = 4'hf;
    // Held select, then a word carrying the final flag
    hold = 1; fcs = 0;
    xfer(w, d);
    `CHK(sel_at_rx, 4'he)
    fin_bit = 1;
    xfer(w, d);
    fin_bit = 0;
    `CHK(sel_at_rx, 4'hf)
    // Held select at divisor one: second word goes out twice
    div = 32'h01010101; n0 = nrxv; n1 = nrdy;
    xfer(w, d);
    xfer(w, d);
    repeat (40) @(negedge clk);
    `CHK(nrxv - n0, 3)
    `CHK(nrdy - n1, 2)
    hold = 0;
    mst = 0; ssel_n = 0;
    repeat (16) #400 sck_in = ~sck_in;
    pulse(0);
    `CHK(act, 1'b1)
    ssel_n = 1;
    pulse(2); pulse(2);
    `CHK(act, 1'b0)
    wrap_up;
  end
endmodule
